// ### design/sacc_adc_map.svh
// Register offsets, field positions, reset values and timing counts
// for the converter configuration and control block.
// Assumes an 8-bit special-function register port with 8-bit addresses.
`ifndef SACC_ADC_MAP_SVH
`define SACC_ADC_MAP_SVH

// Register offsets on the special-function register port
`define SACC_CFG_ADDR      8'hbc
`define SACC_CTRL_ADDR     8'he8

// Reset values
`define SACC_CFG_RST       8'hf8
`define SACC_CTRL_RST      8'h00

// Control register field positions
`define SACC_EN_BIT        7
`define SACC_TM_BIT        6
`define SACC_DONE_BIT      5
`define SACC_BUSY_BIT      4
`define SACC_CM_HI         3
`define SACC_CM_LO         2
`define SACC_WIN_BIT       1
`define SACC_LJ_BIT        0

// Start source encodings
`define SACC_CM_SOFT       2'h0
`define SACC_CM_TMR3       2'h1
`define SACC_CM_EXT        2'h2
`define SACC_CM_TMR2       2'h3

// Phase lengths in conversion clocks
`define SACC_TRACK_CLKS    5'h03
`define SACC_CONV_CLKS     5'h10

`endif

// ### design/sacc_adc_pkg.sv
// Types shared by the converter configuration and control block.
// Assumes the constants of sacc_adc_map.svh are visible to users.
package sacc_adc_pkg;

	// Conversion sequencer states
	typedef enum logic [1:0] {
		SACC_IDLE  = 2'b00,
		SACC_TRACK = 2'b01,
		SACC_CONV  = 2'b10
	} sacc_state_t;

	// Clock and gain configuration register layout
	typedef struct packed {
		logic [4:0] sarClockDivider;
		logic [2:0] pgaGainSelect;
	} sacc_cfg_t;

	// Control register layout
	typedef struct packed {
		logic       converterEnable;
		logic       trackingModeSelect;
		logic       conversionDoneFlag;
		logic       conversionInProgress;
		logic [1:0] startSourceSelect;
		logic       windowCompareFlag;
		logic       leftJustifySelect;
	} sacc_ctrl_t;

endpackage

// ### design/sacc_adc_ctrl.sv
// Configuration and control registers of the successive-approximation
// converter: conversion clock divider, gain select, start and tracking
// sequencing, busy indication and the conversion-done flag.
// Assumes all inputs are synchronous to sys_clk and that the register port
// issues single-cycle read and write strobes.
//
// Overview of operation
// - Conversion clock is system clock over 2(div+1)
// - Divider zero runs conversion clock at system rate
// - Tracking mode set: start source times tracking
// - Done flag sets on finish, drives interrupt
// - Only software clears done flag
// - Done flag sets as busy falls
// - Busy reads one during timed tracking and conversion
// - Software start in tracking mode: three tracking clocks, then conversion
`include "sacc_adc_map.svh"
`timescale 1ns/1ps

module sacc_adc_ctrl
	import sacc_adc_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Special-function register port
	input  wire logic [7:0] sfrAddr,
	input  wire logic       sfrWrEn,
	input  wire logic       sfrRdEn,
	input  wire logic [7:0] sfrWrData,
	output logic      [7:0] sfrRdData,
	// Start sources
	input  wire logic       timer3Overflow,
	input  wire logic       timer2Overflow,
	input  wire logic       extConvStart,
	// Converter controls
	output logic      [2:0] pgaGainSelect,
	output logic            sarClockTick,
	output logic            converterActive,
	output logic            trackEnable,
	output logic            conversionActive,
	output logic            conversionDoneIrq
);

	// ************************************************************
	// Register file
	// ************************************************************
	sacc_cfg_t   cfg_q;
	sacc_ctrl_t  ctrl_q;
	sacc_state_t state_q, state_d;
	logic [5:0]  divCnt_q, divCnt_d;
	logic [4:0]  phaseCnt_q, phaseCnt_d;
	logic        extPrev_q;
	logic        done_d;
	logic [7:0]  rdData_d;

	// Address decode
	wire cfgSel  = (sfrAddr == `SACC_CFG_ADDR);
	wire ctrlSel = (sfrAddr == `SACC_CTRL_ADDR);
	wire cfgWr   = sfrWrEn & cfgSel;
	wire ctrlWr  = sfrWrEn & ctrlSel;

	// Control fields in force, the written value takes effect next cycle
	wire       enable   = ctrl_q.converterEnable;
	wire       trackSel = ctrl_q.trackingModeSelect;
	wire [1:0] source   = ctrl_q.startSourceSelect;
	wire       busy     = (state_q != SACC_IDLE);

	// ************************************************************
	// Conversion clock divider
	// ************************************************************
	// Period is 2(div+1) system clocks, but a zero divider gives full rate
	wire [5:0] divLast = (cfg_q.sarClockDivider == 5'h00) ? 6'h00 :
	                     {cfg_q.sarClockDivider, 1'b1};
	wire       tick    = (divCnt_q == 6'h00);
	assign divCnt_d = tick ? divLast : divCnt_q - 6'h01;

	// ************************************************************
	// Start detection
	// ************************************************************
	wire softStart = ctrlWr & sfrWrData[`SACC_BUSY_BIT];
	wire extRise   = extConvStart & ~extPrev_q;
	wire startHit  = (source == `SACC_CM_SOFT) ? softStart :
	                 (source == `SACC_CM_TMR3) ? timer3Overflow :
	                 (source == `SACC_CM_EXT)  ? extRise : timer2Overflow;
	wire startReq  = enable & ~busy & startHit;
	// External source tracks while its pin is low, so no timed tracking
	wire timedTrack = trackSel & (source != `SACC_CM_EXT);
	wire phaseEnd   = tick & (phaseCnt_q == 5'h00);
	wire convEnd    = (state_q == SACC_CONV) & phaseEnd;

	// ************************************************************
	// Sequencer
	// ************************************************************
	// Dropping enable aborts a conversion without a completion, except one whose last conversion clock ends in the first cycle enable is low
	always_comb begin
		state_d    = state_q;
		phaseCnt_d = phaseCnt_q;
		if (!enable) begin
			state_d    = SACC_IDLE;
			phaseCnt_d = 5'h00;
		end else begin
			case (state_q)
				SACC_IDLE: begin
					if (startReq && timedTrack) begin
						state_d    = SACC_TRACK;
						phaseCnt_d = `SACC_TRACK_CLKS - 5'h01;
					end else if (startReq) begin
						state_d    = SACC_CONV;
						phaseCnt_d = `SACC_CONV_CLKS - 5'h01;
					end
				end
				SACC_TRACK: begin
					if (phaseEnd) begin
						state_d    = SACC_CONV;
						phaseCnt_d = `SACC_CONV_CLKS - 5'h01;
					end else if (tick) begin
						phaseCnt_d = phaseCnt_q - 5'h01;
					end
				end
				SACC_CONV: begin
					if (phaseEnd) begin
						state_d = SACC_IDLE;
					end else if (tick) begin
						phaseCnt_d = phaseCnt_q - 5'h01;
					end
				end
				default: begin
					state_d = SACC_IDLE;
				end
			endcase
		end
	end

	// Completion sets the flag in the same edge that busy falls; a set wins
	// over a software clear in the same cycle
	assign done_d = convEnd ? 1'b1 :
	                ctrlWr  ? sfrWrData[`SACC_DONE_BIT] : ctrl_q.conversionDoneFlag;

	// Read mux, unmapped addresses read as zero
	assign rdData_d = cfgSel  ? cfg_q :
	                  ctrlSel ? {ctrl_q[7:5], busy, ctrl_q[3:0]} : 8'h00;

	// Tracking: continuous when enabled, idle and tracking mode clear, else the timed or pin window
	wire track_d = enable & ((~trackSel & (state_d == SACC_IDLE)) |
	               (state_d == SACC_TRACK) |
	               (trackSel & (source == `SACC_CM_EXT) & ~extConvStart & (state_d == SACC_IDLE)));

	// ************************************************************
	// Flip-flops
	// ************************************************************
	// Register writes
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q  <= `SACC_CFG_RST;
			ctrl_q <= `SACC_CTRL_RST;
		end else begin
			if (cfgWr) begin
				cfg_q <= sfrWrData;
			end
			if (ctrlWr) begin
				ctrl_q <= sfrWrData;
			end
			ctrl_q.conversionDoneFlag   <= done_d;
			ctrl_q.conversionInProgress <= busy;
		end
	end

	// Sequencer and divider state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= SACC_IDLE;
			divCnt_q   <= 6'h00;
			phaseCnt_q <= 5'h00;
			extPrev_q  <= 1'b0;
		end else begin
			state_q    <= state_d;
			divCnt_q   <= divCnt_d;
			phaseCnt_q <= phaseCnt_d;
			extPrev_q  <= extConvStart;
		end
	end

	// Registered outputs
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sfrRdData         <= 8'h00;
			pgaGainSelect     <= 3'h0;
			sarClockTick      <= 1'b0;
			converterActive   <= 1'b0;
			trackEnable       <= 1'b0;
			conversionActive  <= 1'b0;
			conversionDoneIrq <= 1'b0;
		end else begin
			sfrRdData         <= sfrRdEn ? rdData_d : sfrRdData;
			pgaGainSelect     <= cfg_q.pgaGainSelect;
			sarClockTick      <= tick;
			converterActive   <= enable;
			trackEnable       <= track_d;
			conversionActive  <= (state_d == SACC_CONV);
			conversionDoneIrq <= done_d;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Once a zero divider has reloaded, the next cycle must tick again
	a_div_zero_rate: assert property (cfg_q.sarClockDivider == 5'h00 && tick |=> tick)
		else $error("Zero divider must tick every cycle");
	a_div_period: assert property (tick && $stable(cfg_q) ##1 $stable(cfg_q) |-> divCnt_q == divLast)
		else $error("Divider reload value wrong");
	a_track_three: assert property (state_q == SACC_IDLE && state_d == SACC_TRACK |=>
		phaseCnt_q == 5'h02)
		else $error("Tracking must last three conversion clocks");
	a_track_gate: assert property (state_q == SACC_TRACK |-> timedTrack)
		else $error("Timed tracking without tracking mode");
	a_done_on_fall: assert property (convEnd && enable |=> ctrl_q.conversionDoneFlag && state_q == SACC_IDLE)
		else $error("Done flag not set as busy falls");
	a_done_sticky: assert property (ctrl_q.conversionDoneFlag && !ctrlWr |=> ctrl_q.conversionDoneFlag)
		else $error("Done flag cleared without software");
	a_done_irq: assert property (convEnd |=> conversionDoneIrq)
		else $error("Interrupt request differs from done flag");
	a_shutdown: assert property (!enable |=> state_q == SACC_IDLE && !converterActive)
		else $error("Converter not shut down");
	a_busy_read: assert property (sfrRdEn && ctrlSel |=> sfrRdData[`SACC_BUSY_BIT] == $past(busy))
		else $error("Busy readback wrong");

	c_soft_conv: cover property (softStart && startReq ##[1:300] convEnd);
	c_tracked:   cover property (state_q == SACC_TRACK ##[1:300] state_q == SACC_CONV);
	c_set_clear: cover property (convEnd && ctrlWr && !sfrWrData[`SACC_DONE_BIT]);

endmodule

// ### testbench/sacc_adc_ctrl_tb.sv
// Self-checking bench for the converter configuration and control block.
// Assumes the register map header and package are compiled ahead of it.
`include "sacc_adc_map.svh"
`timescale 1ns/1ps

module sacc_adc_ctrl_tb
	import sacc_adc_pkg::*;
;
	// Compare helper: counts every check, reports and counts misses
	`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

	// ************************************************************
	// Stimulus and observed signals
	// ************************************************************
	logic       sys_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [7:0] sfrAddr = 8'h00;
	logic       sfrWrEn = 1'b0;
	logic       sfrRdEn = 1'b0;
	logic [7:0] sfrWrData = 8'h00;
	logic [7:0] sfrRdData;
	logic       timer3Overflow = 1'b0;
	logic       timer2Overflow = 1'b0;
	logic       extConvStart = 1'b0;
	logic [2:0] pgaGainSelect;
	logic       sarClockTick, converterActive, trackEnable, conversionActive, conversionDoneIrq;
	int         n_mismatch = 0;
	int         compares = 0;

	// 4 ns period
	always #2 sys_clk = ~sys_clk;

	sacc_adc_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .timer3Overflow(timer3Overflow),
		.timer2Overflow(timer2Overflow), .extConvStart(extConvStart), .pgaGainSelect(pgaGainSelect),
		.sarClockTick(sarClockTick), .converterActive(converterActive), .trackEnable(trackEnable),
		.conversionActive(conversionActive), .conversionDoneIrq(conversionDoneIrq));

	// ************************************************************
	// Register port and measurement tasks
	// ************************************************************
	// Strobes rise and fall on falling edges so the rising edge sees them settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk) begin sfrAddr = a; sfrWrData = d; sfrWrEn = 1'b1; end
		@(negedge sys_clk) sfrWrEn = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge sys_clk) begin sfrAddr = a; sfrRdEn = 1'b1; end
		@(negedge sys_clk) sfrRdEn = 1'b0;
		`CHK(sfrRdData, exp)
	endtask

	// Distance in system clocks between two conversion clock ticks
	task automatic tick_gap(input int exp);
		int n;
		n = 0;
		while (sarClockTick !== 1'b1 && n < 200) begin n++; @(negedge sys_clk); end
		n = 0;
		do begin n++; @(negedge sys_clk); end while (sarClockTick !== 1'b1 && n < 200);
		`CHK(n, exp)
	endtask

	// Tracking then conversion lengths, bounded so a stuck phase cannot hang
	task automatic run_meas(input int expTrk, input int expCnv);
		int t, c;
		t = 0;
		c = 0;
		while (trackEnable === 1'b1 && t < 100) begin t++; @(negedge sys_clk); end
		while (conversionActive === 1'b1 && c < 100) begin c++; @(negedge sys_clk); end
		`CHK(t, expTrk)
		`CHK(c, expCnv)
		`CHK(conversionDoneIrq, 1'b1)
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_reset();
		rd(`SACC_CFG_ADDR, `SACC_CFG_RST);
		rd(`SACC_CTRL_ADDR, `SACC_CTRL_RST);
		`CHK(converterActive, 1'b0)
		`CHK(pgaGainSelect, 3'h0)
		$display("test_reset done");
	endtask

	// Largest divider first: 2 x 32 clocks per tick, then 4, then full rate
	task automatic test_clock();
		wr(`SACC_CTRL_ADDR, 8'h80);
		// Output copies lag the register by one clock
		@(negedge sys_clk);
		`CHK(converterActive, 1'b1)
		tick_gap(64);
		wr(`SACC_CFG_ADDR, 8'h0d);
		@(negedge sys_clk);
		`CHK(pgaGainSelect, 3'h5)
		tick_gap(4);
		wr(`SACC_CFG_ADDR, 8'h05);
		tick_gap(1);
		wr(8'h00, 8'hff);
		rd(8'h00, 8'h00);
		rd(`SACC_CFG_ADDR, 8'h05);
		$display("test_clock done");
	endtask

	// Flag must outlive the conversion until software writes it low
	task automatic test_soft();
		wr(`SACC_CTRL_ADDR, 8'h90);
		run_meas(0, 16);
		rd(`SACC_CTRL_ADDR, 8'ha0);
		repeat (20) @(negedge sys_clk);
		`CHK(conversionDoneIrq, 1'b1)
		wr(`SACC_CTRL_ADDR, 8'h80);
		`CHK(conversionDoneIrq, 1'b0)
		$display("test_soft done");
	endtask

	// Every start source, with timed tracking where the mode asks for it
	task automatic test_sources();
		wr(`SACC_CTRL_ADDR, 8'hc0);
		wr(`SACC_CTRL_ADDR, 8'hd0);
		run_meas(3, 16);
		wr(`SACC_CTRL_ADDR, 8'hc4);
		@(negedge sys_clk) timer3Overflow = 1'b1;
		@(negedge sys_clk) timer3Overflow = 1'b0;
		run_meas(3, 16);
		wr(`SACC_CTRL_ADDR, 8'hcc);
		@(negedge sys_clk) timer2Overflow = 1'b1;
		@(negedge sys_clk) timer2Overflow = 1'b0;
		run_meas(3, 16);
		// Pin source in tracking mode: tracks while the pin is low, no timed phase
		wr(`SACC_CTRL_ADDR, 8'hc8);
		@(negedge sys_clk);
		`CHK(trackEnable, 1'b1)
		@(negedge sys_clk) extConvStart = 1'b1;
		@(negedge sys_clk) extConvStart = 1'b0;
		run_meas(0, 16);
		wr(`SACC_CTRL_ADDR, 8'h88);
		@(negedge sys_clk) extConvStart = 1'b1;
		@(negedge sys_clk) extConvStart = 1'b0;
		run_meas(0, 16);
		$display("test_sources done");
	endtask

	// Disable in mid-conversion aborts without a completion
	task automatic test_abort();
		wr(`SACC_CTRL_ADDR, 8'h80);
		wr(`SACC_CTRL_ADDR, 8'h90);
		rd(`SACC_CTRL_ADDR, 8'h90);
		wr(`SACC_CTRL_ADDR, 8'h00);
		// Enable falls after the write edge, the abort shows one clock later
		@(negedge sys_clk);
		`CHK(conversionActive, 1'b0)
		`CHK(conversionDoneIrq, 1'b0)
		rd(`SACC_CTRL_ADDR, 8'h00);
		$display("test_abort done");
	endtask

	// ************************************************************
	// Run control
	// ************************************************************
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Whole sequence takes well under 1000 clocks
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		close_out();
	end

	initial begin
		repeat (20) @(negedge sys_clk);
		rst_n = 1'b1;
		test_reset();
		test_clock();
		test_soft();
		test_sources();
		test_abort();
		close_out();
	end
endmodule
